/* design/ctp_lane.sv */
// count lane: pin synchronisers, clock source select, gating and prescaler
`timescale 1ns/1ps
`default_nettype none
module ctp_lane (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // external pins
  input wire logic count_pin_i,
  input wire logic gate_pin_i,
  // configuration and events
  ctp_lane_if.lane lif
);
  logic [1:0] pin_sync_r;
  logic [1:0] gate_sync_r;
  logic pin_prev_r;
  logic gate_prev_r;
  logic [7:0] pcnt_r;
  logic [7:0] pcnt_nxt;
  wire active;
  wire pin_rise;
  wire gate_lvl;
  wire gated;
  wire src;
  wire at_lim;
  wire step;
  wire [7:0] lim;

  // source selection and gating
  assign active = lif.run & ~(lif.halt & lif.idle);
  assign pin_rise = pin_sync_r[1] & ~pin_prev_r;
  assign gate_lvl = gate_sync_r[1];
  assign gated = lif.gate_en & ~lif.ext_sel;
  assign src = lif.ext_sel ? pin_rise : (gated ? gate_lvl : 1'h1);
  assign lim = ctp_pkg::ps_limit(lif.ps_sel);
  assign at_lim = pcnt_r >= lim;
  assign step = active & src;
  assign lif.tick = step & at_lim;
  assign lif.gate_fall = active & gated & gate_prev_r & ~gate_lvl;
  // prescaler restarts on a configuration write or while stopped
  assign pcnt_nxt = (lif.cfg_wr | ~active) ? 8'h00 : (step ? (at_lim ? 8'h00 : pcnt_r + 8'h01) : pcnt_r);

  // synchronisers, edge history and prescaler
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_sync_r <= 2'h0;
      gate_sync_r <= 2'h0;
      pin_prev_r <= 1'h0;
      gate_prev_r <= 1'h0;
      pcnt_r <= 8'h00;
    end else begin
      pin_sync_r <= {pin_sync_r[0], count_pin_i};
      gate_sync_r <= {gate_sync_r[0], gate_pin_i};
      pin_prev_r <= pin_sync_r[1];
      gate_prev_r <= gate_sync_r[1];
      pcnt_r <= pcnt_nxt;
    end
  end
endmodule : ctp_lane
`default_nettype wire

/* design/ctp_top.sv */
// top: cascadable pair of 16-bit timers with an apb register slave
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ctp_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ctp_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // device state and pins
  input wire logic idle_i,
  input wire logic low_word_count_pin_i,
  input wire logic high_word_count_pin_i,
  input wire logic low_word_gate_pin_i,
  input wire logic high_word_gate_pin_i,
  // timer flags
  output logic low_flag_o,
  output logic high_flag_o
);
  // registers
  logic [15:0] ctrl_lo_r;
  logic [15:0] ctrl_lo_nxt;
  logic [15:0] ctrl_hi_r;
  logic [15:0] ctrl_hi_nxt;
  logic [15:0] per_lo_r;
  logic [15:0] per_lo_nxt;
  logic [15:0] per_hi_r;
  logic [15:0] per_hi_nxt;
  logic [15:0] cnt_lo_r;
  logic [15:0] cnt_lo_nxt;
  logic [15:0] cnt_hi_r;
  logic [15:0] cnt_hi_nxt;
  logic flag_lo_r;
  logic flag_lo_nxt;
  logic flag_hi_r;
  logic flag_hi_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  ctp_lane_if lo_if ();
  ctp_lane_if hi_if ();

  // merge a bus write into a register under byte strobes and field mask
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] be;
    be = {{8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~be) | (wd & be)) & mask;
  endfunction : wmerge

  // apb address decode
  wire setup = psel_i & ~penable_i;
  wire wr_acc = psel_i & penable_i & pready_r & pwrite_i;
  wire sel_ctrl_lo = paddr_i == ctp_pkg::OFF_CTRL_LO;
  wire sel_ctrl_hi = paddr_i == ctp_pkg::OFF_CTRL_HI;
  wire sel_per_lo = paddr_i == ctp_pkg::OFF_PER_LO;
  wire sel_per_hi = paddr_i == ctp_pkg::OFF_PER_HI;
  wire sel_cnt_lo = paddr_i == ctp_pkg::OFF_CNT_LO;
  wire sel_cnt_hi = paddr_i == ctp_pkg::OFF_CNT_HI;
  wire sel_flags = paddr_i == ctp_pkg::OFF_FLAGS;
  wire hit = sel_ctrl_lo | sel_ctrl_hi | sel_per_lo | sel_per_hi | sel_cnt_lo | sel_cnt_hi | sel_flags;
  wire wr_ctrl_lo = wr_acc & sel_ctrl_lo;
  wire wr_ctrl_hi = wr_acc & sel_ctrl_hi;
  wire wr_per_lo = wr_acc & sel_per_lo;
  wire wr_per_hi = wr_acc & sel_per_hi;
  wire wr_cnt_lo = wr_acc & sel_cnt_lo;
  wire wr_cnt_hi = wr_acc & sel_cnt_hi;
  wire wr_flags = wr_acc & sel_flags;
  wire [15:0] wd16 = pwdata_i[15:0];
  wire [1:0] st2 = pstrb_i[1:0];

  // read data select, upper half always zero
  wire [15:0] rd16 =
    sel_ctrl_lo ? ctrl_lo_r :
    sel_ctrl_hi ? ctrl_hi_r :
    sel_per_lo ? per_lo_r :
    sel_per_hi ? per_hi_r :
    sel_cnt_lo ? cnt_lo_r :
    sel_cnt_hi ? cnt_hi_r :
    sel_flags ? {14'h0, flag_hi_r, flag_lo_r} : 16'h0000;

  // apb answer: ready in the first access cycle, error on a miss
  assign pready_nxt = setup;
  assign pslverr_nxt = setup & ~hit;
  assign prdata_nxt = (setup & ~pwrite_i) ? {16'h0000, rd16} : 32'h0000_0000;

  // control register decode
  wire joined = ctrl_lo_r[ctp_pkg::BIT_JOIN];
  wire run_lo = ctrl_lo_r[ctp_pkg::BIT_RUN];
  wire run_hi = ctrl_hi_r[ctp_pkg::BIT_RUN] & ~joined;

  // low lane follows the low control register in both modes
  assign lo_if.run = run_lo;
  assign lo_if.halt = ctrl_lo_r[ctp_pkg::BIT_HALT];
  assign lo_if.idle = idle_i;
  assign lo_if.gate_en = ctrl_lo_r[ctp_pkg::BIT_GATE];
  assign lo_if.ext_sel = ctrl_lo_r[ctp_pkg::BIT_EXT];
  assign lo_if.ps_sel = ctrl_lo_r[ctp_pkg::BIT_PS_HI:ctp_pkg::BIT_PS_LO];
  assign lo_if.cfg_wr = wr_ctrl_lo;

  // high lane is held stopped while the pair is joined
  assign hi_if.run = run_hi;
  assign hi_if.halt = ctrl_hi_r[ctp_pkg::BIT_HALT];
  assign hi_if.idle = idle_i;
  assign hi_if.gate_en = ctrl_hi_r[ctp_pkg::BIT_GATE];
  assign hi_if.ext_sel = ctrl_hi_r[ctp_pkg::BIT_EXT];
  assign hi_if.ps_sel = ctrl_hi_r[ctp_pkg::BIT_PS_HI:ctp_pkg::BIT_PS_LO];
  assign hi_if.cfg_wr = wr_ctrl_hi | wr_ctrl_lo;

  // lane instances
  ctp_lane u_lane_lo (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .count_pin_i(low_word_count_pin_i),
    .gate_pin_i(low_word_gate_pin_i),
    .lif(lo_if)
  );

  ctp_lane u_lane_hi (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .count_pin_i(high_word_count_pin_i),
    .gate_pin_i(high_word_gate_pin_i),
    .lif(hi_if)
  );

  // count and period comparison
  wire tick_lo = lo_if.tick;
  wire tick_hi = hi_if.tick;
  wire [31:0] cnt32 = {cnt_hi_r, cnt_lo_r};
  wire [31:0] per32 = {per_hi_r, per_lo_r};
  wire [31:0] inc32 = cnt32 + 32'h0000_0001;
  wire match32 = cnt32 == per32;
  wire match_lo = cnt_lo_r == per_lo_r;
  wire match_hi = cnt_hi_r == per_hi_r;
  wire tick32 = joined & tick_lo;

  // next counts: a bus write wins over a tick
  wire [15:0] lo_step = joined ? (match32 ? 16'h0000 : inc32[15:0]) : (match_lo ? 16'h0000 : cnt_lo_r + 16'h0001);
  wire [15:0] hi_step32 = match32 ? 16'h0000 : inc32[31:16];
  wire [15:0] hi_step16 = match_hi ? 16'h0000 : cnt_hi_r + 16'h0001;
  assign cnt_lo_nxt = wr_cnt_lo ? wmerge(cnt_lo_r, wd16, st2, 16'hFFFF) : (tick_lo ? lo_step : cnt_lo_r);
  assign cnt_hi_nxt = wr_cnt_hi ? wmerge(cnt_hi_r, wd16, st2, 16'hFFFF) :
                      tick32 ? hi_step32 : (tick_hi ? hi_step16 : cnt_hi_r);

  // flag events: the joined pair reports only through the high flag
  wire ev_lo = ~joined & ((tick_lo & match_lo) | lo_if.gate_fall);
  wire ev_hi = joined ? ((tick_lo & match32) | lo_if.gate_fall) : ((tick_hi & match_hi) | hi_if.gate_fall);
  wire clr_lo = wr_flags & st2[0] & wd16[ctp_pkg::BIT_FLAG_LO];
  wire clr_hi = wr_flags & st2[0] & wd16[ctp_pkg::BIT_FLAG_HI];
  // a new event wins over a clear in the same cycle
  assign flag_lo_nxt = ev_lo | (flag_lo_r & ~clr_lo);
  assign flag_hi_nxt = ev_hi | (flag_hi_r & ~clr_hi);

  // control and period writes, reserved bits masked to zero
  assign ctrl_lo_nxt = wr_ctrl_lo ? wmerge(ctrl_lo_r, wd16, st2, ctp_pkg::MASK_CTRL_LO) : ctrl_lo_r;
  assign ctrl_hi_nxt = wr_ctrl_hi ? wmerge(ctrl_hi_r, wd16, st2, ctp_pkg::MASK_CTRL_HI) : ctrl_hi_r;
  assign per_lo_nxt = wr_per_lo ? wmerge(per_lo_r, wd16, st2, 16'hFFFF) : per_lo_r;
  assign per_hi_nxt = wr_per_hi ? wmerge(per_hi_r, wd16, st2, 16'hFFFF) : per_hi_r;

  // register file
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_lo_r <= ctp_pkg::RST_CTRL;
      ctrl_hi_r <= ctp_pkg::RST_CTRL;
      per_lo_r <= ctp_pkg::RST_PER;
      per_hi_r <= ctp_pkg::RST_PER;
      cnt_lo_r <= ctp_pkg::RST_CNT;
      cnt_hi_r <= ctp_pkg::RST_CNT;
      flag_lo_r <= 1'h0;
      flag_hi_r <= 1'h0;
    end else begin
      ctrl_lo_r <= ctrl_lo_nxt;
      ctrl_hi_r <= ctrl_hi_nxt;
      per_lo_r <= per_lo_nxt;
      per_hi_r <= per_hi_nxt;
      cnt_lo_r <= cnt_lo_nxt;
      cnt_hi_r <= cnt_hi_nxt;
      flag_lo_r <= flag_lo_nxt;
      flag_hi_r <= flag_hi_nxt;
    end
  end

  // apb answer registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'h0;
      pslverr_r <= 1'h0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // outputs straight from flip-flops
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign low_flag_o = flag_lo_r;
  assign high_flag_o = flag_hi_r;

  // checks on the design's own behaviour
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // a joined tick that is neither a wrap nor overwritten
  sequence s_join_step;
    joined && tick_lo && !match32 && !wr_cnt_lo && !wr_cnt_hi;
  endsequence

  // a joined tick landing on the period
  sequence s_join_wrap;
    joined && tick_lo && match32 && !wr_cnt_lo && !wr_cnt_hi;
  endsequence

  // a 1:8 prescaled tick on the plain internal clock
  sequence s_div8_tick;
    lo_if.tick && lo_if.ps_sel == 2'h1 && !lo_if.ext_sel && !lo_if.gate_en && !wr_ctrl_lo;
  endsequence

  a_join_carry: assert property (s_join_step |=> {cnt_hi_r, cnt_lo_r} == $past(cnt32) + 32'h0000_0001)
    else $error("joined count did not step as one 32-bit word");

  a_join_wrap: assert property (s_join_wrap |=> cnt32 == 32'h0000_0000 && flag_hi_r)
    else $error("joined period match did not clear count and set high flag");

  a_idle_lo: assert property (lo_if.halt && idle_i |-> !lo_if.tick)
    else $error("low timer ticked in idle with halt set");

  a_idle_hi: assert property (hi_if.halt && idle_i |-> !hi_if.tick)
    else $error("high timer ticked in idle with halt set");

  a_join_hi_off: assert property (joined |-> !hi_if.tick && !hi_if.gate_fall)
    else $error("high lane active while pair joined");

  a_join_lo_flag: assert property ($rose(flag_lo_r) |-> !$past(joined))
    else $error("low flag set while pair joined");

  a_div8_gap: assert property (s_div8_tick |=> (!lo_if.tick) [*7] or (##[0:6] wr_ctrl_lo))
    else $error("1:8 prescaler ticked too soon");

  a_ext_no_gate: assert property (lo_if.ext_sel |-> !lo_if.gate_fall)
    else $error("gate event with external clock selected");

  a_gate_flag: assert property (!joined && lo_if.gate_fall && !wr_ctrl_lo |=> flag_lo_r)
    else $error("gate falling edge did not set low flag");

  a_sep_wrap: assert property (!joined && tick_hi && match_hi && !wr_cnt_hi |=> cnt_hi_r == 16'h0000 && flag_hi_r)
    else $error("high timer period match did not wrap");

  a_stop_hold: assert property (!run_lo && !wr_cnt_lo |=> $stable(cnt_lo_r))
    else $error("low count moved while stopped");

  a_read_zero: assert property (prdata_r[31:16] == 16'h0000 && (ctrl_lo_r & ~ctp_pkg::MASK_CTRL_LO) == 16'h0000)
    else $error("unimplemented bits not zero");

  a_apb_ready: assert property (psel_i && !penable_i |=> pready_r)
    else $error("slave not ready in first access cycle");
endmodule : ctp_top
`default_nettype wire

/* shared/ctp_lane_if.sv */
// interface: configuration into one count lane and its events back out
`timescale 1ns/1ps
`default_nettype none
interface ctp_lane_if;
  logic run;
  logic halt;
  logic idle;
  logic gate_en;
  logic ext_sel;
  logic cfg_wr;
  logic [1:0] ps_sel;
  logic tick;
  logic gate_fall;
  modport lane (
    input run, halt, idle, gate_en, ext_sel, cfg_wr, ps_sel,
    output tick, gate_fall
  );
  modport ctl (
    output run, halt, idle, gate_en, ext_sel, cfg_wr, ps_sel,
    input tick, gate_fall
  );
endinterface : ctp_lane_if
`default_nettype wire

/* shared/ctp_pkg.sv */
// package: register map, field positions, reset values and prescale decode
package ctp_pkg;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL_LO = 12'h000;
  localparam logic [11:0] OFF_CTRL_HI = 12'h004;
  localparam logic [11:0] OFF_PER_LO = 12'h008;
  localparam logic [11:0] OFF_PER_HI = 12'h00C;
  localparam logic [11:0] OFF_CNT_LO = 12'h010;
  localparam logic [11:0] OFF_CNT_HI = 12'h014;
  localparam logic [11:0] OFF_FLAGS = 12'h018;
  // control field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_HALT = 13;
  localparam int BIT_GATE = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_JOIN = 3;
  localparam int BIT_EXT = 1;
  // flag register field positions
  localparam int BIT_FLAG_LO = 0;
  localparam int BIT_FLAG_HI = 1;
  // implemented control bits
  localparam logic [15:0] MASK_CTRL_LO = 16'hA07A;
  localparam logic [15:0] MASK_CTRL_HI = 16'hA072;
  // values after reset
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_PER = 16'hFFFF;
  localparam logic [15:0] RST_CNT = 16'h0000;
  // prescaler terminal counts
  localparam logic [7:0] PS_LIM_1 = 8'h00;
  localparam logic [7:0] PS_LIM_8 = 8'h07;
  localparam logic [7:0] PS_LIM_64 = 8'h3F;
  localparam logic [7:0] PS_LIM_256 = 8'hFF;
  typedef enum logic [1:0] {PS_DIV_1, PS_DIV_8, PS_DIV_64, PS_DIV_256} ctp_ps_t;

  // terminal count of the prescaler for a select code
  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    logic [7:0] lim;
    lim = PS_LIM_1;
    unique case (ctp_ps_t'(sel))
      PS_DIV_1: lim = PS_LIM_1;
      PS_DIV_8: lim = PS_LIM_8;
      PS_DIV_64: lim = PS_LIM_64;
      PS_DIV_256: lim = PS_LIM_256;
    endcase
    return lim;
  endfunction : ps_limit
endpackage : ctp_pkg

/* verif/ctp_tb.sv */
// testbench: apb register checks and timer scenarios for the cascadable timer pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin err_total++; \
  $display("mismatch t=%0t value got %h exp %h", $time, g, x); end end
module tb;
  localparam logic [15:0] RUN = 16'h8000;
  localparam logic [15:0] HALT = 16'h2000;
  localparam logic [15:0] GATE = 16'h0040;
  localparam logic [15:0] JOIN = 16'h0008;
  localparam logic [15:0] EXT = 16'h0002;
  localparam int SH [4] = '{0, 3, 6, 8};
  // design inputs, outputs and bench state
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic idle_i = 1'b0;
  logic [1:0] pin = 2'h0;
  logic [1:0] pin_en = 2'h0;
  logic [1:0] gate = 2'h0;
  logic [1:0] pdiv = 2'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic low_flag_o;
  logic high_flag_o;
  logic [31:0] rdq;
  logic rde;
  logic [11:0] co;
  logic [11:0] ko;
  logic [11:0] po;
  int err_total = 0;
  int checks_done = 0;

  // clock at 100 MHz
  always #5 ref_clk_i = ~ref_clk_i;

  // external count pulses: a rising edge every eight clocks while enabled
  always @(posedge ref_clk_i) begin
    pdiv <= pdiv + 2'h1;
    if (pdiv == 2'h3) pin <= pin_en & ~pin;
  end

  ctp_top dut (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(4'h3),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .idle_i(idle_i),
    .low_word_count_pin_i(pin[0]),
    .high_word_count_pin_i(pin[1]),
    .low_word_gate_pin_i(gate[0]),
    .high_word_gate_pin_i(gate[1]),
    .low_flag_o(low_flag_o),
    .high_flag_o(high_flag_o)
  );

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // one apb transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {16'h0000, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // no cycle count is assumed here: only the watchdog ends a wait that never sees pready
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    rdq = prdata_o;
    rde = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // read a register and compare the whole word
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 16'h0000);
    `CHK(rdq, x)
  endtask : rdc

  // count within two of the expected figure, to absorb the phase of external count edges
  function automatic logic near(input logic [15:0] g, input logic [15:0] x);
    return ((g > x) ? g - x : x - g) <= 16'h0002;
  endfunction : near

  // clear the count, run with a control word for a span, stop, compare the count
  task automatic meas(input logic [15:0] c, input int cyc, input logic [15:0] x);
    wr(ko, 16'h0000);
    wr(co, c);
    // the stopping write lands three edges after its call, so the run lasts exactly cyc clocks
    repeat (cyc - 3) @(posedge ref_clk_i);
    wr(co, c & ~RUN);
    apb(1'b0, ko, 16'h0000);
    `CHK(near(rdq[15:0], x), 1'b1)
  endtask : meas

  // watchdog against a hung handshake or a stalled sequence
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    err_total++;
    $display("mismatch t=%0t watchdog expired", $time);
    stop_test();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rdc(ctp_pkg::OFF_CTRL_LO, 32'h00000000);
    rdc(ctp_pkg::OFF_CTRL_HI, 32'h00000000);
    rdc(ctp_pkg::OFF_FLAGS, 32'h00000000);
    apb(1'b0, 12'h01C, 16'hFFFF);
    `CHK({rde, rdq}, 33'h100000000)
    // unimplemented control bits read back as zero
    wr(ctp_pkg::OFF_CTRL_HI, 16'hFFFF);
    rdc(ctp_pkg::OFF_CTRL_HI, 32'h0000A072);
    wr(ctp_pkg::OFF_CTRL_LO, 16'hFFFF);
    rdc(ctp_pkg::OFF_CTRL_LO, 32'h0000A07A);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h0000);
    for (int l = 0; l < 2; l++) begin
      co = (l == 1) ? ctp_pkg::OFF_CTRL_HI : ctp_pkg::OFF_CTRL_LO;
      ko = (l == 1) ? ctp_pkg::OFF_CNT_HI : ctp_pkg::OFF_CNT_LO;
      po = (l == 1) ? ctp_pkg::OFF_PER_HI : ctp_pkg::OFF_PER_LO;
      for (int p = 0; p < 4; p++) begin
        meas(RUN | 16'(p << 4), 1024, 16'(1024 >> SH[p]));
      end
      meas(16'h0000, 256, 16'h0000);
      idle_i <= 1'b1;
      meas(RUN | HALT, 256, 16'h0000);
      meas(RUN, 256, 16'h0100);
      idle_i <= 1'b0;
      meas(RUN | GATE, 256, 16'h0000);
      gate[l] <= 1'b1;
      meas(RUN | GATE, 256, 16'h0100);
      gate[l] <= 1'b0;
      pin_en[l] <= 1'b1;
      meas(RUN | GATE | EXT, 400, 16'h0032);
      meas(RUN | EXT | 16'h0010, 800, 16'h000C);
      pin_en[l] <= 1'b0;
      // falling gate while running raises only this lane's flag
      wr(ctp_pkg::OFF_FLAGS, 16'h0003);
      gate[l] <= 1'b1;
      wr(co, RUN | GATE);
      repeat (20) @(posedge ref_clk_i);
      gate[l] <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      `CHK({high_flag_o, low_flag_o}, (l == 1) ? 2'b10 : 2'b01)
      wr(co, 16'h0000);
      // short period: match wraps the count and sets the flag
      wr(ctp_pkg::OFF_FLAGS, 16'h0003);
      wr(po, 16'h0009);
      wr(ko, 16'h0000);
      wr(co, RUN);
      repeat (100) @(posedge ref_clk_i);
      `CHK({high_flag_o, low_flag_o}, (l == 1) ? 2'b10 : 2'b01)
      wr(co, 16'h0000);
      apb(1'b0, ko, 16'h0000);
      `CHK(rdq[15:0] <= 16'h0009, 1'b1)
      wr(po, 16'hFFFF);
    end
    // joined pair: carry into the high word, high control ignored, idle with halt clear
    wr(ctp_pkg::OFF_FLAGS, 16'h0003);
    wr(ctp_pkg::OFF_PER_LO, 16'h0100);
    wr(ctp_pkg::OFF_PER_HI, 16'h0001);
    wr(ctp_pkg::OFF_CNT_LO, 16'hFFF0);
    wr(ctp_pkg::OFF_CNT_HI, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_HI, HALT | GATE | EXT | 16'h0030);
    idle_i <= 1'b1;
    wr(ctp_pkg::OFF_CTRL_LO, RUN | JOIN);
    repeat (40) @(posedge ref_clk_i);
    wr(ctp_pkg::OFF_CTRL_LO, JOIN);
    rdc(ctp_pkg::OFF_CNT_HI, 32'h00000001);
    apb(1'b0, ctp_pkg::OFF_CNT_LO, 16'h0000);
    `CHK(near(rdq[15:0], 16'h001B), 1'b1)
    `CHK({high_flag_o, low_flag_o}, 2'b00)
    wr(ctp_pkg::OFF_CTRL_LO, RUN | JOIN);
    repeat (300) @(posedge ref_clk_i);
    `CHK({high_flag_o, low_flag_o}, 2'b10)
    rdc(ctp_pkg::OFF_FLAGS, 32'h00000002);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    idle_i <= 1'b0;
    // joined gated pair: a fall on the low gate pin reports through the high flag only
    wr(ctp_pkg::OFF_FLAGS, 16'h0003);
    gate[0] <= 1'b1;
    wr(ctp_pkg::OFF_CTRL_LO, RUN | JOIN | GATE);
    repeat (20) @(posedge ref_clk_i);
    gate[0] <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    `CHK({high_flag_o, low_flag_o}, 2'b10)
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    wr(ctp_pkg::OFF_FLAGS, 16'h0003);
    rdc(ctp_pkg::OFF_FLAGS, 32'h00000000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
